// File: rtl/actc_defines.vh
// Notes on behaviour
// - Audio rate = 2*busclk/(64*div), div 8..127
// - Odd audio divisor counts both clock edges
// - Line rate = 2*busclk/(64*div), div 16..127
// - Odd line divisor counts both clock edges
// - Control 13 bit 13 disables offset cancel
// - Input gain field steps 1.5 dB
// - Clip detect sets sticky clip flag
// - Rising voice clip edge raises interrupt when enabled
// - Falling voice clip edge raises interrupt when enabled
// - Attenuation 3 dB steps, analog then digital
// - Mute keeps speaker powered, signal off
// - Input and output paths enabled separately
// - Mic ground switch floats when input off
// - Loopback feeds output to input, mic ignored
// - Voiceband filter only while enable set
// - Line mute keeps driver on, no signal
// - Line loopback joins output to input
// - Converters tick at 64 times sample rate
`ifndef ACTC_DEFINES_VH
`define ACTC_DEFINES_VH

`define ACTC_ADDR_W        4
`define ACTC_DATA_W        16
// Register indices
`define ACTC_REG_VOICE_A   4'h0
`define ACTC_REG_VOICE_B   4'h1
`define ACTC_REG_LINE_A    4'h2
`define ACTC_REG_LINE_B    4'h3
`define ACTC_REG_IRQ_STAT  4'h4
`define ACTC_REG_CTRL13    4'hd
// Field positions
`define ACTC_DIV_LSB       0
`define ACTC_DIV_MSB       6
`define ACTC_GAIN_LSB      7
`define ACTC_GAIN_MSB      11
`define ACTC_ATT_LSB       0
`define ACTC_ATT_MSB       4
`define ACTC_VB_IN_EN      5
`define ACTC_VB_OUT_EN     6
`define ACTC_VB_LOOP       7
`define ACTC_VB_MUTE       8
`define ACTC_VB_RISE_IE    9
`define ACTC_VB_FALL_IE    10
`define ACTC_VB_CLIP       11
`define ACTC_LB_VBF_EN     0
`define ACTC_LB_MUTE       1
`define ACTC_LB_LOOP       2
`define ACTC_LB_CLIP       3
`define ACTC_LB_IN_EN      4
`define ACTC_LB_OUT_EN     5
`define ACTC_IS_RISE       0
`define ACTC_IS_FALL       1
`define ACTC_C13_OFS_DIS   13
// Reset values
`define ACTC_RST_DIV       7'h0c
`define ACTC_RST_LINE_DIV  7'h28
`define ACTC_RST_ZERO      16'h0000
// Timing
`define ACTC_OVERSAMPLE    6'h3f
`define ACTC_ATT_MAX       5'h17
`define ACTC_ATT_STEPS     5'h08

`endif

// File: rtl/actc_codec_ctrl.v
`timescale 1ns/1ps
`include "actc_defines.vh"

module actc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;
  assign in_ready  = (count_reg != DEPTH);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
  always @*
  begin
    out_data = mem[rd_ptr_reg[AW-1:0]];
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // actc_fifo
////////////////////////////////////////////////////////////////////////////
module actc_codec_ctrl #(
  parameter SAMPLE_W   = 16,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire                    clk,
  input  wire                    rst_b,
  input  wire [`ACTC_ADDR_W-1:0] reg_addr,
  input  wire [`ACTC_DATA_W-1:0] reg_wdata,
  input  wire                    reg_write,
  input  wire                    reg_read,
  output reg  [`ACTC_DATA_W-1:0] reg_rdata,
  input  wire                    serial_bus_clock,
  input  wire                    voice_clip_detect,
  input  wire                    line_clip_detect,
  input  wire [SAMPLE_W-1:0]     sample_in_data,
  input  wire                    sample_in_valid,
  output wire                    sample_in_ready,
  output wire [SAMPLE_W-1:0]     sample_out_data,
  output wire                    sample_out_valid,
  input  wire                    sample_out_ready,
  output reg                     voice_mod_tick,
  output reg                     voice_sample_tick,
  output reg                     line_mod_tick,
  output reg                     line_sample_tick,
  output reg                     interrupt_output_pin,
  output reg                     offset_cancel_enable,
  output reg  [4:0]              voice_gain_code,
  output reg  [2:0]              analog_atten_code,
  output reg  [1:0]              digital_atten_sel,
  output reg                     voice_input_enable,
  output reg                     voice_output_enable,
  output reg                     speaker_signal_enable,
  output reg                     voice_loop_select,
  output reg                     mic_input_select,
  output reg                     mic_ground_switch_out,
  output reg                     mic_ground_switch_oe_b,
  output reg  [4:0]              line_gain_code,
  output reg                     line_input_enable,
  output reg                     line_output_enable,
  output reg                     line_voiceband_filter_enable,
  output reg                     line_output_silence,
  output reg                     line_loop_select
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  reg [1:0] rst_sync_reg;
  wire      rst_n;
  reg [1:0] sclk_sync_reg;
  reg       sclk_last_reg;
  reg [1:0] vclip_sync_reg;
  reg       vclip_last_reg;
  reg [1:0] lclip_sync_reg;
  wire      sclk_rise;
  wire      sclk_fall;
  wire      vclip_rise;
  wire      vclip_fall;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_sync_reg  <= 2'h0;
      sclk_last_reg  <= 1'b0;
      vclip_sync_reg <= 2'h0;
      vclip_last_reg <= 1'b0;
      lclip_sync_reg <= 2'h0;
    end
    else
    begin
      sclk_sync_reg  <= {sclk_sync_reg[0], serial_bus_clock};
      sclk_last_reg  <= sclk_sync_reg[1];
      vclip_sync_reg <= {vclip_sync_reg[0], voice_clip_detect};
      vclip_last_reg <= vclip_sync_reg[1];
      lclip_sync_reg <= {lclip_sync_reg[0], line_clip_detect};
    end
  end
  assign sclk_rise  = sclk_sync_reg[1] & ~sclk_last_reg;
  assign sclk_fall  = ~sclk_sync_reg[1] & sclk_last_reg;
  assign vclip_rise = vclip_sync_reg[1] & ~vclip_last_reg;
  assign vclip_fall = ~vclip_sync_reg[1] & vclip_last_reg;
  ////////////////////////////////////////////////////////////////////////
  // Register file
  reg [`ACTC_DATA_W-1:0] voice_a_reg;
  reg [`ACTC_DATA_W-1:0] voice_b_reg;
  reg [`ACTC_DATA_W-1:0] line_a_reg;
  reg [`ACTC_DATA_W-1:0] line_b_reg;
  reg [`ACTC_DATA_W-1:0] ctrl13_reg;
  reg                    voice_clip_reg;
  reg                    line_clip_reg;
  reg                    irq_rise_reg;
  reg                    irq_fall_reg;
  wire                   wr_voice_b;
  wire                   wr_line_b;
  wire                   wr_irq;
  assign wr_voice_b = reg_write & (reg_addr == `ACTC_REG_VOICE_B);
  assign wr_line_b  = reg_write & (reg_addr == `ACTC_REG_LINE_B);
  assign wr_irq     = reg_write & (reg_addr == `ACTC_REG_IRQ_STAT);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      voice_a_reg <= {9'h000, `ACTC_RST_DIV};
      voice_b_reg <= `ACTC_RST_ZERO;
      line_a_reg  <= {9'h000, `ACTC_RST_LINE_DIV};
      line_b_reg  <= `ACTC_RST_ZERO;
      ctrl13_reg  <= `ACTC_RST_ZERO;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `ACTC_REG_VOICE_A: voice_a_reg <= reg_wdata;
        `ACTC_REG_VOICE_B: voice_b_reg <= reg_wdata;
        `ACTC_REG_LINE_A:  line_a_reg  <= reg_wdata;
        `ACTC_REG_LINE_B:  line_b_reg  <= reg_wdata;
        `ACTC_REG_CTRL13:  ctrl13_reg  <= reg_wdata;
        default:           ctrl13_reg  <= ctrl13_reg;
      endcase
    end
  end
  // Sticky flags: write one clears, a new event wins over the clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      voice_clip_reg <= 1'b0;
      line_clip_reg  <= 1'b0;
      irq_rise_reg   <= 1'b0;
      irq_fall_reg   <= 1'b0;
    end
    else
    begin
      if (vclip_sync_reg[1])
        voice_clip_reg <= 1'b1;
      else if (wr_voice_b & reg_wdata[`ACTC_VB_CLIP])
        voice_clip_reg <= 1'b0;
      if (lclip_sync_reg[1])
        line_clip_reg <= 1'b1;
      else if (wr_line_b & reg_wdata[`ACTC_LB_CLIP])
        line_clip_reg <= 1'b0;
      if (vclip_rise & voice_b_reg[`ACTC_VB_RISE_IE])
        irq_rise_reg <= 1'b1;
      else if (wr_irq & reg_wdata[`ACTC_IS_RISE])
        irq_rise_reg <= 1'b0;
      if (vclip_fall & voice_b_reg[`ACTC_VB_FALL_IE])
        irq_fall_reg <= 1'b1;
      else if (wr_irq & reg_wdata[`ACTC_IS_FALL])
        irq_fall_reg <= 1'b0;
    end
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `ACTC_RST_ZERO;
    else if (reg_read)
    begin
      case (reg_addr)
        `ACTC_REG_VOICE_A:  reg_rdata <= voice_a_reg;
        `ACTC_REG_VOICE_B:  reg_rdata <= {voice_b_reg[15:12], voice_clip_reg,
                                          voice_b_reg[10:0]};
        `ACTC_REG_LINE_A:   reg_rdata <= line_a_reg;
        `ACTC_REG_LINE_B:   reg_rdata <= {line_b_reg[15:4], line_clip_reg,
                                          line_b_reg[2:0]};
        `ACTC_REG_IRQ_STAT: reg_rdata <= {14'h0, irq_fall_reg,
                                          irq_rise_reg};
        `ACTC_REG_CTRL13:   reg_rdata <= ctrl13_reg;
        default:            reg_rdata <= `ACTC_RST_ZERO;
      endcase
    end
    else
      reg_rdata <= `ACTC_RST_ZERO;
  end
  ////////////////////////////////////////////////////////////////////////
  // Sample rate generators, index 0 voice, index 1 line
  wire [13:0] div_pair;
  wire [1:0]  mod_tick;
  wire [1:0]  smp_tick;
  assign div_pair = {line_a_reg[`ACTC_DIV_MSB:`ACTC_DIV_LSB],
                     voice_a_reg[`ACTC_DIV_MSB:`ACTC_DIV_LSB]};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : rate_gen
      reg  [6:0] edge_cnt_reg;
      reg  [5:0] phase_reg;
      reg        mod_reg;
      reg        smp_reg;
      wire [6:0] dv;
      wire       step;
      wire [6:0] lim;
      assign dv   = div_pair[gi*7+6:gi*7];
      assign step = dv[0] ? (sclk_rise | sclk_fall) : sclk_rise;
      assign lim  = dv[0] ? dv : {1'b0, dv[6:1]};
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          edge_cnt_reg <= 7'h00;
          phase_reg    <= 6'h00;
          mod_reg      <= 1'b0;
          smp_reg      <= 1'b0;
        end
        else
        begin
          mod_reg <= 1'b0;
          smp_reg <= 1'b0;
          if (step)
          begin
            if (edge_cnt_reg >= lim - 7'h01)
            begin
              edge_cnt_reg <= 7'h00;
              mod_reg      <= 1'b1;
              phase_reg    <= phase_reg + 6'h01;
              if (phase_reg == `ACTC_OVERSAMPLE)
                smp_reg <= 1'b1;
            end
            else
              edge_cnt_reg <= edge_cnt_reg + 7'h01;
          end
        end
      end

      assign mod_tick[gi] = mod_reg;
      assign smp_tick[gi] = smp_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Sample buffer toward the serial bus
  actc_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (sample_in_data),
    .in_valid  (sample_in_valid),
    .in_ready  (sample_in_ready),
    .out_data  (sample_out_data),
    .out_valid (sample_out_valid),
    .out_ready (sample_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Analog and filter controls
  wire [4:0] att_clamped;

  assign att_clamped = (voice_b_reg[`ACTC_ATT_MSB:`ACTC_ATT_LSB] >
                        `ACTC_ATT_MAX) ? `ACTC_ATT_MAX :
                       voice_b_reg[`ACTC_ATT_MSB:`ACTC_ATT_LSB];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      voice_mod_tick               <= 1'b0;
      voice_sample_tick            <= 1'b0;
      line_mod_tick                <= 1'b0;
      line_sample_tick             <= 1'b0;
      interrupt_output_pin         <= 1'b0;
      offset_cancel_enable         <= 1'b1;
      voice_gain_code              <= 5'h00;
      analog_atten_code            <= 3'h0;
      digital_atten_sel            <= 2'h0;
      voice_input_enable           <= 1'b0;
      voice_output_enable          <= 1'b0;
      speaker_signal_enable        <= 1'b0;
      voice_loop_select            <= 1'b0;
      mic_input_select             <= 1'b1;
      mic_ground_switch_out        <= 1'b0;
      mic_ground_switch_oe_b       <= 1'b1;
      line_gain_code               <= 5'h00;
      line_input_enable            <= 1'b0;
      line_output_enable           <= 1'b0;
      line_voiceband_filter_enable <= 1'b0;
      line_output_silence          <= 1'b0;
      line_loop_select             <= 1'b0;
    end
    else
    begin
      voice_mod_tick       <= mod_tick[0];
      voice_sample_tick    <= smp_tick[0];
      line_mod_tick        <= mod_tick[1];
      line_sample_tick     <= smp_tick[1];
      interrupt_output_pin <= irq_rise_reg | irq_fall_reg;
      offset_cancel_enable <= ~ctrl13_reg[`ACTC_C13_OFS_DIS];
      // gain code in 1.5 dB steps
      voice_gain_code      <= voice_a_reg[`ACTC_GAIN_MSB:`ACTC_GAIN_LSB];
      // analog 0..21 dB, digital 24/48 dB
      analog_atten_code    <= att_clamped[2:0];
      digital_atten_sel    <= att_clamped[4:3];
      voice_input_enable   <= voice_b_reg[`ACTC_VB_IN_EN];
      voice_output_enable  <= voice_b_reg[`ACTC_VB_OUT_EN];
      speaker_signal_enable <= voice_b_reg[`ACTC_VB_OUT_EN] &
                               ~voice_b_reg[`ACTC_VB_MUTE];
      voice_loop_select    <= voice_b_reg[`ACTC_VB_LOOP];
      mic_input_select     <= ~voice_b_reg[`ACTC_VB_LOOP];
      // mic ground floats when input off
      mic_ground_switch_out  <= 1'b0;
      mic_ground_switch_oe_b <= ~voice_b_reg[`ACTC_VB_IN_EN];
      line_gain_code       <= line_a_reg[`ACTC_GAIN_MSB:`ACTC_GAIN_LSB];
      line_input_enable    <= line_b_reg[`ACTC_LB_IN_EN];
      line_output_enable   <= line_b_reg[`ACTC_LB_OUT_EN];
      line_voiceband_filter_enable <= line_b_reg[`ACTC_LB_VBF_EN];
      line_output_silence  <= line_b_reg[`ACTC_LB_MUTE];
      line_loop_select     <= line_b_reg[`ACTC_LB_LOOP];
    end
  end

endmodule // actc_codec_ctrl

// File: dv/actc_codec_ctrl_checker.sv
`timescale 1ns/1ps
module actc_codec_ctrl_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        voice_clip_detect,
  input wire logic        line_clip_detect,
  input wire logic        voice_mod_tick,
  input wire logic        voice_sample_tick,
  input wire logic        line_mod_tick,
  input wire logic        line_sample_tick,
  input wire logic        interrupt_output_pin,
  input wire logic        offset_cancel_enable,
  input wire logic [1:0]  digital_atten_sel,
  input wire logic        voice_input_enable,
  input wire logic        voice_loop_select,
  input wire logic        mic_input_select,
  input wire logic        mic_ground_switch_out,
  input wire logic        mic_ground_switch_oe_b,
  input wire logic        line_voiceband_filter_enable
);
  logic [7:0] vcnt_reg;
  logic [7:0] lcnt_reg;
  logic [3:0] since_reg;
  logic [1:0] clip_reg;

  // Mod ticks per frame, cycles since a clip change
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vcnt_reg <= 8'h00;
      lcnt_reg <= 8'h00;
      since_reg <= 4'hf;
      clip_reg <= 2'h0;
    end
    else
    begin
      clip_reg <= {voice_clip_detect, line_clip_detect};
      if (clip_reg != {voice_clip_detect, line_clip_detect})
        since_reg <= 4'h0;
      else if (since_reg != 4'hf)
        since_reg <= since_reg + 4'h1;
      if (voice_sample_tick)
        vcnt_reg <= 8'h00;
      else if (voice_mod_tick)
        vcnt_reg <= vcnt_reg + 8'h01;
      if (line_sample_tick)
        lcnt_reg <= 8'h00;
      else if (line_mod_tick)
        lcnt_reg <= lcnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  chk_unmapped_zero: assert property ($past(reg_read && reg_addr == 4'h7)
    |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_offset_write: assert property ($changed(offset_cancel_enable) |->
    $past(reg_write && reg_addr == 4'hd) ||
    $past(reg_write && reg_addr == 4'hd, 2)) else $error("offset flip");
  chk_mic_float: assert property (mic_ground_switch_oe_b ==
    !voice_input_enable && !mic_ground_switch_out) else $error("mic gnd");
  chk_loop_mic: assert property (mic_input_select ==
    !voice_loop_select) else $error("mic not ignored in loopback");
  chk_filter_write: assert property ($changed(line_voiceband_filter_enable)
    |-> $past(reg_write && reg_addr == 4'h3) ||
    $past(reg_write && reg_addr == 4'h3, 2)) else $error("filter flip");
  chk_voice_frame: assert property (voice_sample_tick |->
    vcnt_reg + voice_mod_tick == 8'h40) else $error("voice frame count");
  chk_line_frame: assert property (line_sample_tick |->
    lcnt_reg + line_mod_tick == 8'h40) else $error("line frame count");
  chk_voice_pulse: assert property (voice_mod_tick |=>
    !voice_mod_tick [*3]) else $error("voice tick too close");
  chk_line_pulse: assert property (line_mod_tick |=>
    !line_mod_tick [*3]) else $error("line tick too close");
  chk_atten_sel: assert property (digital_atten_sel != 2'h3)
    else $error("bad digital attenuation");
  chk_irq_cause: assert property ($rose(interrupt_output_pin) |->
    since_reg < 4'h8) else $error("irq without clip edge");
  chk_irq_clear: assert property ($fell(interrupt_output_pin) |->
    $past(reg_write && reg_addr == 4'h4) ||
    $past(reg_write && reg_addr == 4'h4, 2)) else $error("irq dropped");
endmodule // actc_codec_ctrl_checker

bind actc_codec_ctrl actc_codec_ctrl_checker u_chk (
  .clk, .rst_b, .reg_addr, .reg_write, .reg_read, .reg_rdata,
  .voice_clip_detect, .line_clip_detect, .voice_mod_tick,
  .voice_sample_tick, .line_mod_tick, .line_sample_tick,
  .interrupt_output_pin, .offset_cancel_enable, .digital_atten_sel,
  .voice_input_enable, .voice_loop_select, .mic_input_select,
  .mic_ground_switch_out, .mic_ground_switch_oe_b,
  .line_voiceband_filter_enable
);

// File: dv/actc_sysctl_model.sv
`timescale 1ns/1ps
module actc_sysctl_model #(
  parameter HALF_NS = 100
) (
  input  wire logic run,
  output logic      serial_bus_clock
);
  initial serial_bus_clock = 1'b0;

  always #HALF_NS serial_bus_clock = run ? ~serial_bus_clock : 1'b0;
endmodule // actc_sysctl_model

// File: dv/test_actc_codec_ctrl.sv
`timescale 1ns/1ps
module test_actc_codec_ctrl;
  logic        clk, rst_b, reg_write, reg_read, serial_bus_clock, run;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, sample_in_data, sample_out_data, g, e;
  logic        voice_clip_detect, line_clip_detect, sample_in_valid;
  logic        sample_in_ready, sample_out_valid, sample_out_ready;
  logic        voice_mod_tick, voice_sample_tick, line_mod_tick;
  logic        line_sample_tick, interrupt_output_pin, offset_cancel_enable;
  logic [4:0]  voice_gain_code, line_gain_code;
  logic [2:0]  analog_atten_code;
  logic [1:0]  digital_atten_sel;
  logic        voice_input_enable, voice_output_enable, speaker_signal_enable;
  logic        voice_loop_select, mic_input_select, mic_ground_switch_out;
  logic        mic_ground_switch_oe_b, line_input_enable, line_output_enable;
  logic        line_voiceband_filter_enable, line_output_silence;
  logic        line_loop_select;
  logic [3:0]  tk;
  int          bad_count, n_compared;

  assign tk = {line_sample_tick, line_mod_tick, voice_sample_tick,
               voice_mod_tick};

  actc_codec_ctrl dut (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .serial_bus_clock, .voice_clip_detect, .line_clip_detect,
    .sample_in_data, .sample_in_valid, .sample_in_ready, .sample_out_data,
    .sample_out_valid, .sample_out_ready, .voice_mod_tick,
    .voice_sample_tick, .line_mod_tick, .line_sample_tick,
    .interrupt_output_pin, .offset_cancel_enable, .voice_gain_code,
    .analog_atten_code, .digital_atten_sel, .voice_input_enable,
    .voice_output_enable, .speaker_signal_enable, .voice_loop_select,
    .mic_input_select, .mic_ground_switch_out, .mic_ground_switch_oe_b,
    .line_gain_code, .line_input_enable, .line_output_enable,
    .line_voiceband_filter_enable, .line_output_silence, .line_loop_select
  );

  actc_sysctl_model u_sc (.run(run), .serial_bus_clock(serial_bus_clock));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask

  task st;
    repeat (8) @(negedge clk);
  endtask

  // Third tick spacing; earlier ones may straddle a divisor change
  task meas(input int s, input logic [15:0] x);
    int c;
    for (int r = 0; r < 3; r++)
    begin
      c = 1;
      @(negedge clk);
      while (tk[s] !== 1'b1 && c < 9000)
      begin
        c++;
        @(negedge clk);
      end
    end
    chk(c[15:0], x);
  endtask

  task print_verdict;
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #1500000;
    bad_count++;
    print_verdict;
  end

  initial
  begin
    int c;
    rst_b = 1'b0;
    run = 1'b1;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    {voice_clip_detect, line_clip_detect, sample_in_valid} = '0;
    sample_in_data = 16'h0000;
    sample_out_ready = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h0, 16'h000c);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0028);
    rd(4'h3, 16'h0000);
    rd(4'h4, 16'h0000);
    rd(4'hd, 16'h0000);
    rd(4'h7, 16'h0000);
    g = {13'h0, offset_cancel_enable, mic_input_select, mic_ground_switch_oe_b};
    chk(g, 16'h0007);
    wr(4'hd, 16'h2000);
    st;
    chk({15'h0, offset_cancel_enable}, 16'h0000);
    wr(4'h0, 16'h080c);
    st;
    chk({11'h0, voice_gain_code}, 16'h0010);
    wr(4'h2, 16'h0fa8);
    st;
    chk({11'h0, line_gain_code}, 16'h001f);
    for (int k = 0; k < 32; k++)
    begin
      wr(4'h1, {11'h0, k[4:0]});
      st;
      c = (k > 23) ? 23 : k;
      chk({11'h0, digital_atten_sel, analog_atten_code}, c[15:0]);
    end
    for (int k = 0; k < 16; k++)
    begin
      wr(4'h1, {7'h0, k[3:0], 5'h00});
      st;
      g = {11'h0, voice_input_enable, voice_output_enable, voice_loop_select,
           mic_input_select, mic_ground_switch_oe_b};
      e = {11'h0, k[0], k[1], k[2], ~k[2], ~k[0]};
      chk(g, e);
      if (k[1])
        chk({15'h0, speaker_signal_enable}, {15'h0, ~k[3]});
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(4'h3, {10'h0, 2'h3, 1'b0, k[2:0]});
      st;
      g = {11'h0, line_voiceband_filter_enable, line_output_silence,
           line_loop_select, line_input_enable, line_output_enable};
      chk(g, {11'h0, k[0], k[1], k[2], 2'h3});
    end
    @(posedge clk);
    line_clip_detect <= 1'b1;
    st;
    rd(4'h3, 16'h003f);
    @(posedge clk);
    line_clip_detect <= 1'b0;
    wr(4'h1, 16'h0200);
    voice_clip_detect <= 1'b1;
    st;
    chk({15'h0, interrupt_output_pin}, 16'h0001);
    rd(4'h1, 16'h0a00);
    rd(4'h4, 16'h0001);
    wr(4'h4, 16'h0001);
    st;
    chk({15'h0, interrupt_output_pin}, 16'h0000);
    @(posedge clk);
    voice_clip_detect <= 1'b0;
    st;
    chk({15'h0, interrupt_output_pin}, 16'h0000);
    wr(4'h1, 16'h0c00);
    st;
    rd(4'h1, 16'h0400);
    @(posedge clk);
    voice_clip_detect <= 1'b1;
    st;
    chk({15'h0, interrupt_output_pin}, 16'h0000);
    @(posedge clk);
    voice_clip_detect <= 1'b0;
    st;
    chk({15'h0, interrupt_output_pin}, 16'h0001);
    rd(4'h4, 16'h0002);
    wr(4'h4, 16'h0002);
    st;
    chk({15'h0, interrupt_output_pin}, 16'h0000);
    wr(4'h0, 16'h000c);
    meas(0, 16'd48);
    wr(4'h0, 16'h0009);
    meas(0, 16'd36);
    wr(4'h0, 16'h007f);
    meas(0, 16'd508);
    wr(4'h0, 16'h0008);
    meas(0, 16'd32);
    meas(1, 16'd2048);
    wr(4'h2, 16'h0028);
    meas(2, 16'd160);
    wr(4'h2, 16'h0011);
    meas(2, 16'd68);
    wr(4'h2, 16'h0010);
    meas(2, 16'd64);
    meas(3, 16'd4096);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      sample_in_valid <= 1'b1;
      sample_in_data <= 16'h5a00 + i[15:0];
    end
    @(posedge clk);
    sample_in_data <= 16'hdead;
    @(posedge clk);
    sample_in_valid <= 1'b0;
    @(negedge clk);
    chk({15'h0, sample_in_ready}, 16'h0000);
    @(posedge clk);
    sample_out_ready <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk);
      chk(sample_out_data, 16'h5a00 + i[15:0]);
    end
    @(posedge clk);
    sample_out_ready <= 1'b0;
    @(negedge clk);
    chk({14'h0, sample_out_valid, sample_in_ready}, 16'h0001);
    print_verdict;
  end
endmodule // test_actc_codec_ctrl
